// ==== bench/cycle_logger_assertions.sv ====
// port-level assertions for the cycle logger
`timescale 1ns/1ps
module cycle_logger_assertions #(
  parameter int SEC_CYCLES = 20
) (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_reset,
  // watched inputs
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic signed [15:0] i_current,
  input wire logic i_eod_fault,
  input wire logic i_controller_link_fail,
  // watched outputs
  input wire logic o_pready,
  input wire logic o_pslverr,
  input wire logic [1:0] o_batt_status,
  input wire logic o_cycle_active,
  input wire logic o_buffer_alarm
);
  // the alarm must stand at least thirty second ticks
  localparam int HOLD = 30 * SEC_CYCLES;
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_reset);
  // cycles the alarm has stood, zero while it is low
  int unsigned hold_q;
  always_ff @(posedge i_clock) begin
    if (i_reset || !o_buffer_alarm) hold_q <= 0;
    else hold_q <= hold_q + 1;
  end
  a_ready_wait: assert property (i_psel && i_penable && !o_pready |=> o_pready)
    else $error("pready not one cycle after access");
  a_ready_pulse: assert property (o_pready |=> !o_pready)
    else $error("pready longer than one cycle");
  a_err_with_ready: assert property (o_pslverr |-> o_pready)
    else $error("pslverr without pready");
  a_status_charge: assert property ((i_current > 100) [*3] |-> o_batt_status == 2'h1)
    else $error("status not charging");
  a_status_dis: assert property ((i_current < -100) [*3] |-> o_batt_status == 2'h2)
    else $error("status not discharging");
  a_normal_band: assert property ((i_current >= -100 && i_current <= 100) [*3]
    |-> o_batt_status == 2'h0 && !o_cycle_active) else $error("normal band not idle");
  a_no_start: assert property ((!o_cycle_active && i_current >= -200) [*2]
    |=> !o_cycle_active) else $error("cycle started below threshold");
  a_eod_end: assert property (i_eod_fault [*4] |-> !o_cycle_active)
    else $error("cycle active during end of discharge");
  a_link_end: assert property (i_controller_link_fail [*4] |-> !o_cycle_active)
    else $error("cycle active during link loss");
  a_alarm_hold: assert property (o_buffer_alarm && hold_q < HOLD |=> o_buffer_alarm)
    else $error("alarm dropped too early");
endmodule : cycle_logger_assertions

bind cycle_logger cycle_logger_assertions #(.SEC_CYCLES(SEC_CYCLES)) u_chk (
  .i_clock(i_clock), .i_reset(i_reset), .i_psel(i_psel), .i_penable(i_penable),
  .i_current(i_current), .i_eod_fault(i_eod_fault),
  .i_controller_link_fail(i_controller_link_fail), .o_pready(o_pready),
  .o_pslverr(o_pslverr), .o_batt_status(o_batt_status),
  .o_cycle_active(o_cycle_active), .o_buffer_alarm(o_buffer_alarm));

// ==== bench/feed_model.sv ====
// measurement feed model: readings, stamps and fault lines toward the logger
`timescale 1ns/1ps
module feed_model (
  // clock
  input wire logic i_clock,
  // settings from the bench
  input wire logic signed [15:0] i_amps,
  input wire logic [9:0] i_volts,
  input wire logic signed [7:0] i_degc,
  input wire logic i_eod,
  input wire logic i_link_lost,
  // feed to the logger
  output logic signed [15:0] o_current,
  output logic [9:0] o_bus_volts,
  output logic signed [7:0] o_temp,
  output logic [23:0] o_date,
  output logic [23:0] o_time,
  output logic o_eod_fault,
  output logic o_controller_link_fail
);
  logic [15:0] stamp_q;
  // meter readings follow the bench settings directly
  assign o_current = i_amps;
  assign o_bus_volts = i_volts;
  assign o_temp = i_degc;
  assign o_eod_fault = i_eod;
  assign o_controller_link_fail = i_link_lost;
  assign o_date = 24'h030901;
  // fixed hour byte tells time from date; low bits run each clock
  assign o_time = {8'h12, stamp_q};
  initial stamp_q = 16'h0000;
  always @(posedge i_clock) begin
    stamp_q <= stamp_q + 16'h0001;
  end
endmodule : feed_model

// ==== bench/tb_top.sv ====
// self-checking bench for the cycle logger
`timescale 1ns/1ps
`include "cycle_logger_map.svh"
module tb_top;
  localparam int SEC = 20;
  localparam logic [15:0] KEY = 16'h1d2e; // arbitrary value
  logic i_clock, i_reset, psel, penable, pwrite, pready, pslverr, err;
  logic eod, lost, efault, lfault, active, alarm;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic signed [15:0] amps, cur;
  logic [9:0] volts, bv;
  logic signed [7:0] degc, tmp;
  logic [23:0] dte, tod;
  logic [1:0] bstat;
  int fails, compares, n;

  cycle_logger #(.SEC_CYCLES(SEC), .PASSWORD(KEY)) u_dut (
    .i_clock(i_clock), .i_reset(i_reset), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .i_current(cur), .i_bus_volts(bv),
    .i_temp(tmp), .i_date(dte), .i_time(tod), .i_eod_fault(efault),
    .i_controller_link_fail(lfault), .o_batt_status(bstat),
    .o_cycle_active(active), .o_buffer_alarm(alarm));
  feed_model u_feed (
    .i_clock(i_clock), .i_amps(amps), .i_volts(volts), .i_degc(degc), .i_eod(eod),
    .i_link_lost(lost), .o_current(cur), .o_bus_volts(bv), .o_temp(tmp),
    .o_date(dte), .o_time(tod), .o_eod_fault(efault), .o_controller_link_fail(lfault));

  // 100 MHz clock
  initial begin
    i_clock = 1'b0;
    forever #5 i_clock = ~i_clock;
  end

  task automatic complete_run(input bit hung);
    if (hung) fails++;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : complete_run

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic chk_bit(input string what, input logic exp, input logic got);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("BAD %s expected %b seen %b", what, exp, got);
    end
  endtask : chk_bit

  // one apb transfer; request held until pready is seen at a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge i_clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge i_clock);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge i_clock);
      k++;
    end while (pready !== 1'b1 && k < 40);
    if (k >= 40) complete_run(1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
                     input string what);
    apb(1'b0, a, 32'h00000000);
    chk(what, e, rd & m);
  endtask : rdc

  // short discharge, well inside the first duration bucket
  task automatic pulse_cycle();
    @(posedge i_clock);
    amps <= 16'hfed4;
    repeat (4) @(posedge i_clock);
    amps <= 16'h0000;
    repeat (4) @(posedge i_clock);
    n++;
  endtask : pulse_cycle

  initial begin
    i_reset = 1'b1;
    {psel, penable, pwrite, eod, lost} = 5'h00;
    paddr = 8'h00;
    pwdata = 32'h00000000;
    amps = 16'h0000;
    volts = 10'h1c2;
    degc = 8'h19;
    {fails, compares, n} = {32'h0, 32'h0, 32'h0};
    repeat (5) @(posedge i_clock);
    i_reset <= 1'b0;
    rdc(`OFS_CTRL, 32'hffffffff, 32'h27100001, "ctrl");
    rdc(`OFS_COUNT, 32'hffffffff, 32'h00000000, "count");
    apb(1'b0, 8'h30, 32'h00000000);
    chk_bit("slverr", 1'b1, err);
    chk("unmapped", 32'h00000000, rd);
    $display("test reset done");
    amps <= 16'h0096;
    repeat (5) @(posedge i_clock);
    rdc(`OFS_STATUS, 32'h1f, 32'h01, "status charge");
    amps <= 16'hff38;
    repeat (5) @(posedge i_clock);
    rdc(`OFS_STATUS, 32'h1f, 32'h02, "status at threshold");
    amps <= 16'hff37;
    repeat (5) @(posedge i_clock);
    rdc(`OFS_STATUS, 32'h1f, 32'h06, "status started");
    // record of a 50 s cycle
    amps <= 16'hfe3e;
    repeat (2) @(posedge i_clock);
    amps <= 16'hfed4;
    volts <= 10'h1ae;
    repeat (10) @(posedge i_clock);
    volts <= 10'h1bd;
    degc <= 8'h3c;
    repeat (50 * SEC) @(posedge i_clock);
    amps <= 16'h0000;
    repeat (5) @(posedge i_clock);
    n = 1;
    rdc(`OFS_COUNT, 32'hffffffff, 32'h00010101, "count one");
    apb(1'b1, `OFS_RECSEL, 32'h00000000);
    rdc(`OFS_REC0, 32'hffffffff, 32'h00004019, "rec0 first");
    rdc(`OFS_REC1, 32'hffffffff, 32'h00030901, "rec1 date");
    rdc(`OFS_REC2, 32'h3ff, 32'h1ae, "rec2 min volts");
    rdc(`OFS_REC3, 32'hfff90000, 32'h0e110000, "rec3 peak");
    apb(1'b1, `OFS_CTRL, 32'h27100003);
    rdc(`OFS_REC1, 32'hffff0000, 32'h00120000, "rec1 time");
    repeat (4 * SEC) @(posedge i_clock);
    rdc(`OFS_REC1, 32'hffffffff, 32'h00030901, "rec1 date again");
    $display("test first cycle done");
    // newest first, temperature out of range
    degc <= 8'hfb;
    pulse_cycle();
    degc <= 8'h19;
    apb(1'b1, `OFS_RECSEL, 32'h00000000);
    rdc(`OFS_REC0, 32'hffffffff, 32'h0001012a, "rec0 newest");
    apb(1'b1, `OFS_RECSEL, 32'h00000001);
    rdc(`OFS_REC0, 32'hffffffff, 32'h00004019, "rec0 older");
    $display("test order done");
    amps <= 16'he000;
    repeat (5) @(posedge i_clock);
    eod <= 1'b1;
    repeat (6) @(posedge i_clock);
    rdc(`OFS_STATUS, 32'h0f, 32'h02, "status after fault");
    amps <= 16'h0000;
    repeat (3) @(posedge i_clock);
    eod <= 1'b0;
    n = 3;
    rdc(`OFS_COUNT, 32'h0000ff00, 32'h00000300, "count after fault");
    apb(1'b1, `OFS_RECSEL, 32'h00000000);
    rdc(`OFS_REC3, 32'hfff80000, 32'hccc80000, "peak limit");
    amps <= 16'hfed4;
    repeat (5) @(posedge i_clock);
    lost <= 1'b1;
    repeat (6) @(posedge i_clock);
    lost <= 1'b0;
    rdc(`OFS_STATUS, 32'h0f, 32'h0a, "holdoff");
    repeat (7 * SEC) @(posedge i_clock);
    rdc(`OFS_STATUS, 32'h0f, 32'h0a, "holdoff at 7 s");
    repeat (5 * SEC) @(posedge i_clock);
    rdc(`OFS_STATUS, 32'h0f, 32'h06, "rearmed");
    amps <= 16'h0000;
    repeat (5) @(posedge i_clock);
    n = 5;
    $display("test faults done");
    apb(1'b1, `OFS_CTRL, 32'h27100000);
    amps <= 16'hfed4;
    repeat (5) @(posedge i_clock);
    rdc(`OFS_STATUS, 32'h0f, 32'h02, "disabled");
    amps <= 16'h0000;
    apb(1'b1, `OFS_CTRL, 32'h27100001);
    while (n < 133) begin
      pulse_cycle();
      if (n == 128) chk_bit("alarm low", 1'b0, alarm);
      if (n == 129) chk_bit("alarm high", 1'b1, alarm);
      if (n == 132) rdc(`OFS_BKT01, 32'hffffffff, 32'h00010083, "buckets");
    end
    rdc(`OFS_COUNT, 32'hffffffff, 32'h00858401, "count wrapped");
    apb(1'b1, `OFS_RECSEL, 32'h00000000);
    rdc(`OFS_REC0, 32'hffff0000, 32'h00840000, "newest id");
    apb(1'b1, `OFS_RECSEL, 32'h00000083);
    apb(1'b1, `OFS_RECSEL, 32'h00000084);
    rdc(`OFS_REC0, 32'hffff0000, 32'h00010000, "oldest id");
    rdc(`OFS_TOT, 32'hffffffff, 32'h00000085, "total cycles");
    rdc(`OFS_TOT + 8'h04, 32'hffffffff, 32'h00000000, "total high");
    $display("test buffer done");
    apb(1'b1, `OFS_ERASE, 32'h12340003);
    rdc(`OFS_COUNT, 32'hffffffff, 32'h00858401, "wrong key");
    apb(1'b1, `OFS_ERASE, {KEY, 16'h0001});
    rdc(`OFS_COUNT, 32'h0000ff00, 32'h00000000, "records erased");
    chk_bit("alarm kept", 1'b1, alarm);
    rdc(`OFS_TOT, 32'hffffffff, 32'h00000085, "totals kept");
    apb(1'b1, `OFS_ERASE, {KEY, 16'h0002});
    rdc(`OFS_TOT, 32'hffffffff, 32'h00000000, "totals erased");
    repeat (31 * SEC) @(posedge i_clock);
    chk_bit("alarm cleared", 1'b0, alarm);
    $display("test erase done");
    complete_run(1'b0);
  end
endmodule : tb_top

// ==== design/cycle_logger.sv ====
// battery discharge cycle logger with apb register access
//
// Notes on behaviour
// RULE1 - start cycle when armed and discharge exceeds 2% of rating
// RULE2 - end cycle and re-arm when current returns within +/-1%
// RULE3 - status charging above +1%, discharging below -1%, else idle
// RULE4 - current handled in tenths of an ampere everywhere
// RULE5 - end-of-discharge fault ends cycle, saves record and totals, re-arms
// RULE6 - controller link failure ends and saves cycle, re-arm after 10 s
// RULE7 - capture date, time and compartment temperature at cycle start
// RULE8 - track lowest bus volts, peak discharge current, accumulate kwh
// RULE9 - store duration with record, update count, amp hours, kwh totals
// RULE10 - duration buckets: <=30, 31-90, 91-240, above 240 seconds
// RULE11 - sequential ids; readout walks records newest first
// RULE12 - duration holds five decimal digits, bus volts three digits
// RULE13 - peak current in tenths, limited to 6553
// RULE14 - kwh shown with decimal below 1000, whole above, max 6553
// RULE15 - temperature outside 0 to 126 shown as an asterisk
// RULE16 - time view shows time stamps for three seconds, then dates
// RULE17 - totals are 64 bits so they never overflow
// RULE18 - records kept in a 132 entry circular buffer
// RULE19 - 133rd record overwrites the oldest, others kept
// RULE20 - above 128 stored cycles raise near-full alarm for at least 30 s
// RULE21 - logging enabled out of reset, can be disabled
// RULE22 - erasing records or totals needs the correct password
// RULE23 - duration counter saturates instead of wrapping
`timescale 1ns/1ps
`include "cycle_logger_map.svh"
module cycle_logger #(
  parameter int SEC_CYCLES = `SEC_NS / `CLK_NS,
  parameter logic [15:0] PASSWORD = 16'h5a3c // arbitrary value
) (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_reset,
  // apb slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // measurement feed, same clock
  input wire logic signed [15:0] i_current,
  input wire logic [9:0] i_bus_volts,
  input wire logic signed [7:0] i_temp,
  input wire logic [23:0] i_date,
  input wire logic [23:0] i_time,
  // fault pins, asynchronous
  input wire logic i_eod_fault,
  input wire logic i_controller_link_fail,
  // status
  output logic [1:0] o_batt_status,
  output logic o_cycle_active,
  output logic o_buffer_alarm
);
  typedef struct packed {
    logic [31:0] divc;
    logic eod_a;
    logic eod_s;
    logic link_a;
    logic link_s;
    cycle_logger_pkg::phase_t phase;
    logic active;
    logic [3:0] holdoff;
    logic enable;
    logic [15:0] rating;
    logic view_time;
    logic [1:0] view_secs;
    logic [1:0] status;
    logic [16:0] dur;
    logic [9:0] minv;
    logic [12:0] peak;
    logic [15:0] kwh;
    logic [27:0] kwh_res;
    logic [15:0] ah;
    logic [16:0] ah_res;
    logic [23:0] st_date;
    logic [23:0] st_time;
    logic [7:0] st_temp;
    logic [15:0] next_id;
    logic [7:0] wptr;
    logic [7:0] stored;
    logic [3:0][15:0] bkt;
    logic [3:0][63:0] tot;
    logic alarm;
    logic [4:0] alarm_secs;
    logic [7:0] rec_sel;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } state_t;

  state_t q;
  state_t d;
  cycle_logger_pkg::rec_t rec;
  cycle_logger_pkg::rec_t rd;
  logic signed [16:0] cur;
  logic signed [16:0] thr1;
  logic signed [16:0] thr2;
  logic [16:0] mag;
  logic tick;
  logic normal;
  logic save;
  logic [1:0] bucket;
  logic [8:0] raddr;
  logic [7:0] ptemp;
  logic tstar;
  logic [16:0] kdisp;
  logic access;
  logic mapped;
  logic [31:0] rdata;
  logic [2:0] tot_ix;

  rec_store_if #(.AW(8)) store_if ();

  cycle_store #(.DEPTH(`DEPTH)) u_store (
    .i_clock(i_clock),
    .port(store_if.store)
  );

  // newest-first readout: index 0 is the latest record
  // RULE11 newest first
  always_comb begin
    raddr = 9'(q.wptr) + 9'(`DEPTH) - 9'h001 - 9'(q.rec_sel);
    if (raddr >= 9'(`DEPTH)) begin
      raddr = raddr - 9'(`DEPTH);
    end
  end

  assign store_if.raddr = raddr[7:0];
  assign store_if.we = save;
  assign store_if.waddr = q.wptr;
  assign store_if.wdata = rec;
  assign rd = store_if.rdata;

  // thresholds and current magnitude
  // RULE4 tenth amp units
  always_comb begin
    cur = {i_current[15], i_current};
    thr1 = $signed((17'(q.rating) * `PCT_CURRENT_IDLE_STATUS) / `PCT_DIV);
    thr2 = $signed((17'(q.rating) * `PCT_START) / `PCT_DIV);
    mag = 17'(-cur);
    // RULE2 normal band
    normal = !(cur > thr1) && !(cur < -thr1);
  end

  // duration bucket of the cycle being closed
  // RULE10 duration buckets
  always_comb begin
    if (q.dur <= `B0_MAX) begin
      bucket = 2'h0;
    end else if (q.dur <= `B1_MAX) begin
      bucket = 2'h1;
    end else if (q.dur <= `B2_MAX) begin
      bucket = 2'h2;
    end else begin
      bucket = 2'h3;
    end
  end

  // record being written at cycle end
  // RULE9 store duration
  always_comb begin
    rec.id = q.next_id;
    rec.bucket = bucket;
    rec.temp = q.st_temp;
    rec.date = q.st_date;
    rec.time_of_day = q.st_time;
    rec.dur = q.dur;
    rec.minv = q.minv;
    rec.peak = q.peak;
    rec.kwh = q.kwh;
  end

  // display forms of the record fields
  always_comb begin
    // RULE15 asterisk out of range
    // flag kept apart, as a real 42 degree reading equals the star code
    if (rd.temp[7] || rd.temp > `TEMP_MAX) begin
      ptemp = `TEMP_STAR;
      tstar = 1'b1;
    end else begin
      ptemp = rd.temp;
      tstar = 1'b0;
    end
    // RULE14 kwh format switch
    if (rd.kwh < `KWH_DEC_LIMIT) begin
      kdisp = {1'b1, rd.kwh};
    end else if (rd.kwh / 16'h000a > `KWH_WHOLE_MAX) begin
      kdisp = {1'b0, `KWH_WHOLE_MAX};
    end else begin
      kdisp = {1'b0, 16'(rd.kwh / 16'h000a)};
    end
  end

  // apb read decode; unmapped offsets answer with pslverr
  always_comb begin
    access = i_psel && i_penable;
    tot_ix = i_paddr[4:2];
    mapped = 1'b1;
    rdata = 32'h0000_0000;
    if (i_paddr[7:5] == 3'h2 && i_paddr[1:0] == 2'h0) begin
      rdata = tot_ix[0] ? q.tot[tot_ix[2:1]][63:32] : q.tot[tot_ix[2:1]][31:0];
    end else begin
      unique case (i_paddr)
        `OFS_CTRL: rdata = {q.rating, 14'h0000, q.view_time, q.enable};
        `OFS_STATUS: rdata = {27'h0000000, q.alarm, q.phase, q.status};
        `OFS_COUNT: rdata = {q.next_id, q.stored, q.wptr};
        `OFS_BKT01: rdata = {q.bkt[1], q.bkt[0]};
        `OFS_BKT23: rdata = {q.bkt[3], q.bkt[2]};
        `OFS_ERASE: rdata = 32'h0000_0000;
        `OFS_RECSEL: rdata = {24'h000000, q.rec_sel};
        `OFS_REC0: rdata = {rd.id, rd.bucket, 5'h00, tstar, ptemp};
        // RULE16 time or date stamp
        `OFS_REC1: rdata = {8'h00, q.view_time ? rd.time_of_day : rd.date};
        `OFS_REC2: rdata = {5'h00, rd.dur, rd.minv};
        `OFS_REC3: rdata = {rd.peak, 2'h0, kdisp};
        default: mapped = 1'b0;
      endcase
    end
  end

  // next state of the whole block
  always_comb begin
    d = q;
    save = 1'b0;
    d.pready = 1'b0;
    d.pslverr = 1'b0;
    // two-stage synchronisers for the fault pins
    d.eod_a = i_eod_fault;
    d.eod_s = q.eod_a;
    d.link_a = i_controller_link_fail;
    d.link_s = q.link_a;
    // one-second enable from the divider
    tick = (q.divc == 32'(SEC_CYCLES - 1));
    d.divc = tick ? 32'h0000_0000 : q.divc + 32'h0000_0001;

    // RULE3 battery status
    if (cur > thr1) begin
      d.status = cycle_logger_pkg::charging_status;
    end else if (cur < -thr1) begin
      d.status = cycle_logger_pkg::discharging_status;
    end else begin
      d.status = cycle_logger_pkg::current_idle_status;
    end

    unique case (q.phase)
      cycle_logger_pkg::ph_armed: begin
        // RULE1 discharge start
        if (q.enable && !q.link_s && !q.eod_s && cur < -thr2) begin
          d.phase = cycle_logger_pkg::ph_active;
          d.dur = 17'h00000;
          d.peak = 13'h0000;
          d.kwh = 16'h0000;
          d.kwh_res = 28'h0000000;
          d.ah = 16'h0000;
          d.ah_res = 17'h00000;
          // RULE7 start stamps
          d.st_date = i_date;
          d.st_time = i_time;
          d.st_temp = i_temp;
          d.minv = i_bus_volts;
        end
      end
      cycle_logger_pkg::ph_active: begin
        // RULE8 minimum volts and peak current
        if (i_bus_volts < q.minv) begin
          d.minv = i_bus_volts;
        end
        // RULE13 peak limit
        if (mag > 17'(`PEAK_MAX) && !cur[16]) begin
          d.peak = q.peak;
        end else if (mag > 17'(`PEAK_MAX)) begin
          d.peak = `PEAK_MAX;
        end else if (cur[16] && mag[12:0] > q.peak) begin
          d.peak = mag[12:0];
        end
        if (tick) begin
          // RULE12 RULE23 duration saturates
          if (q.dur != `DUR_MAX) begin
            d.dur = q.dur + 17'h00001;
          end
          if (cur[16]) begin
            // RULE8 energy and charge
            d.ah_res = q.ah_res + mag;
            if (d.ah_res >= `AH_UNIT) begin
              d.ah_res = d.ah_res - `AH_UNIT;
              d.ah = (q.ah == 16'hffff) ? q.ah : q.ah + 16'h0001;
            end
            d.kwh_res = q.kwh_res + 28'(mag) * 28'(i_bus_volts);
            if (d.kwh_res >= `KWH_UNIT) begin
              d.kwh_res = d.kwh_res - `KWH_UNIT;
              d.kwh = (q.kwh == 16'hffff) ? q.kwh : q.kwh + 16'h0001;
            end
          end
        end
        // RULE6 link failure ends cycle
        if (q.link_s) begin
          save = 1'b1;
          d.phase = cycle_logger_pkg::ph_holdoff;
          d.holdoff = `LINK_HOLD_S;
        // RULE5 end of discharge
        end else if (q.eod_s || normal) begin
          save = 1'b1;
          d.phase = cycle_logger_pkg::ph_armed;
        end
      end
      cycle_logger_pkg::ph_holdoff: begin
        // RULE6 ten second re-arm
        if (tick) begin
          d.holdoff = q.holdoff - 4'h1;
          if (q.holdoff == 4'h1) begin
            d.phase = cycle_logger_pkg::ph_armed;
          end
        end
      end
      default: d.phase = cycle_logger_pkg::ph_armed;
    endcase

    // active flag registered so the output leaves a flip-flop
    d.active = (d.phase == cycle_logger_pkg::ph_active);

    if (save) begin
      // RULE19 circular overwrite
      d.wptr = (q.wptr == 8'(`DEPTH - 1)) ? 8'h00 : q.wptr + 8'h01;
      // RULE18 132 entries
      d.stored = (q.stored == 8'(`DEPTH)) ? q.stored : q.stored + 8'h01;
      // RULE11 sequential ids
      d.next_id = q.next_id + 16'h0001;
      d.bkt[bucket] = q.bkt[bucket] + 16'h0001;
      // RULE17 wide totals
      d.tot[0] = q.tot[0] + 64'h1;
      d.tot[1] = q.tot[1] + 64'(q.dur);
      d.tot[2] = q.tot[2] + 64'(q.ah);
      d.tot[3] = q.tot[3] + 64'(q.kwh);
    end

    // RULE20 near-full alarm with hold
    if (q.stored > `ALARM_LEVEL && !q.alarm) begin
      d.alarm = 1'b1;
      d.alarm_secs = `ALARM_HOLD_S;
    end else if (q.alarm) begin
      if (tick && q.alarm_secs != 5'h00) begin
        d.alarm_secs = q.alarm_secs - 5'h01;
      end
      // one more tick after zero, so the hold never falls under thirty seconds
      if (tick && q.alarm_secs == 5'h00 && q.stored <= `ALARM_LEVEL) begin
        d.alarm = 1'b0;
      end
    end

    // RULE16 three second time view
    if (q.view_time && tick) begin
      d.view_secs = q.view_secs - 2'h1;
      if (q.view_secs == 2'h1) begin
        d.view_time = 1'b0;
      end
    end

    // answer one cycle into the access phase
    if (access && !q.pready) begin
      d.pready = 1'b1;
      d.pslverr = !mapped;
      d.prdata = i_pwrite ? 32'h0000_0000 : rdata;
    end

    // a write takes effect at the edge that samples pready high
    if (access && q.pready && i_pwrite && mapped) begin
      unique case (i_paddr)
        `OFS_CTRL: begin
          // RULE21 enable setting
          d.enable = i_pwdata[`CTRL_ENABLE];
          d.rating = i_pwdata[31:16];
          if (i_pwdata[`CTRL_VIEW]) begin
            d.view_time = 1'b1;
            d.view_secs = `VIEW_HOLD_S;
          end
        end
        `OFS_ERASE: begin
          // RULE22 password check
          if (i_pwdata[31:16] == PASSWORD) begin
            if (i_pwdata[`ERASE_RECS]) begin
              d.wptr = 8'h00;
              d.stored = 8'h00;
              d.bkt = '0;
            end
            if (i_pwdata[`ERASE_SUMM]) begin
              d.tot = '0;
            end
          end
        end
        `OFS_RECSEL: begin
          if (i_pwdata[7:0] < 8'(`DEPTH)) begin
            d.rec_sel = i_pwdata[7:0];
          end
        end
        default: d.rec_sel = q.rec_sel;
      endcase
    end
  end

  // state register; synchronous reset
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      q <= '0;
      q.phase <= cycle_logger_pkg::ph_armed;
      q.status <= cycle_logger_pkg::current_idle_status;
      // RULE21 enabled from reset
      q.enable <= `RST_ENABLE;
      q.rating <= `RST_RATING;
    end else begin
      q <= d;
    end
  end

  // outputs straight from the state register
  assign o_prdata = q.prdata;
  assign o_pready = q.pready;
  assign o_pslverr = q.pslverr;
  assign o_batt_status = q.status;
  assign o_cycle_active = q.active;
  assign o_buffer_alarm = q.alarm;
endmodule : cycle_logger

// ==== design/cycle_logger_map.svh ====
// offsets, field positions, reset values and timing counts of the cycle logger
`ifndef CYCLE_LOGGER_MAP_SVH
`define CYCLE_LOGGER_MAP_SVH
// register byte offsets
`define OFS_CTRL 8'h00
`define OFS_STATUS 8'h04
`define OFS_COUNT 8'h08
`define OFS_BKT01 8'h0c
`define OFS_BKT23 8'h10
`define OFS_ERASE 8'h14
`define OFS_RECSEL 8'h18
`define OFS_REC0 8'h1c
`define OFS_REC1 8'h20
`define OFS_REC2 8'h24
`define OFS_REC3 8'h28
`define OFS_TOT 8'h40
// field positions
`define CTRL_ENABLE 0
`define CTRL_VIEW 1
`define ERASE_RECS 0
`define ERASE_SUMM 1
// reset values
`define RST_ENABLE 1'b1
`define RST_RATING 16'h2710
// thresholds in percent of rating
`define PCT_START 17'h00002
`define PCT_CURRENT_IDLE_STATUS 17'h00001
`define PCT_DIV 17'h00064
// record storage
`define DEPTH 132
`define ALARM_LEVEL 8'h80
// field limits
`define DUR_MAX 17'h1869f
`define PEAK_MAX 13'h1999
`define KWH_DEC_LIMIT 16'h2710
`define KWH_WHOLE_MAX 16'h1999
`define TEMP_MAX 8'h7e
`define TEMP_STAR 8'h2a
`define B0_MAX 17'h0001e
`define B1_MAX 17'h0005a
`define B2_MAX 17'h000f0
// tenth-amp seconds per amp hour, tenth-watt seconds per tenth kwh
`define AH_UNIT 17'h08ca0
`define KWH_UNIT 28'h036ee80
// times
`define CLK_NS 10
`define SEC_NS 1000000000
`define LINK_HOLD_S 4'ha
`define ALARM_HOLD_S 5'h1e
`define VIEW_HOLD_S 2'h3
`endif

// ==== design/cycle_logger_pkg.sv ====
// types shared by the cycle logger modules
package cycle_logger_pkg;
  typedef enum logic [1:0] {
    current_idle_status,
    charging_status,
    discharging_status
  } batt_status_t;

  typedef enum logic [1:0] {ph_armed, ph_active, ph_holdoff} phase_t;

  typedef struct packed {
    logic [15:0] id;
    logic [1:0] bucket;
    logic [7:0] temp;
    logic [23:0] date;
    logic [23:0] time_of_day;
    logic [16:0] dur;
    logic [9:0] minv;
    logic [12:0] peak;
    logic [15:0] kwh;
  } rec_t;
endpackage : cycle_logger_pkg

// ==== design/cycle_store.sv ====
// record memory with registered read data
`timescale 1ns/1ps
`include "cycle_logger_map.svh"
module cycle_store #(
  parameter int DEPTH = `DEPTH
) (
  input wire logic i_clock,
  rec_store_if.store port
);
  cycle_logger_pkg::rec_t mem [DEPTH];
  cycle_logger_pkg::rec_t rdata_q;

  // one write port, one registered read port
  always_ff @(posedge i_clock) begin
    if (port.we) begin
      mem[port.waddr] <= port.wdata;
    end
    rdata_q <= mem[port.raddr];
  end

  assign port.rdata = rdata_q;
endmodule : cycle_store

// ==== design/rec_store_if.sv ====
// record store port between logger and its memory
`timescale 1ns/1ps
interface rec_store_if #(parameter int AW = 8);
  logic we;
  logic [AW-1:0] waddr;
  logic [AW-1:0] raddr;
  cycle_logger_pkg::rec_t wdata;
  cycle_logger_pkg::rec_t rdata;
  modport ctrl (output we, output waddr, output wdata, output raddr, input rdata);
  modport store (input we, input waddr, input wdata, input raddr, output rdata);
endinterface : rec_store_if
